// ---- core/adc_regs.vh ----
// Purpose: register offsets, field positions, reset values and codes of the converter control
// Assumes: 32-bit registers on an AXI4-Lite slave, one aligned word each
// Notes: included by the control and window compare design files of the converter control; the slot picker does not include it
`ifndef ADC_REGS_VH
`define ADC_REGS_VH

// Byte addresses
`define CTRL_OFS 6'h00
`define MODE_OFS 6'h04
`define SEQ_LOW_OFS 6'h08
`define SEQ_HIGH_OFS 6'h0c
`define CHAN_EN_OFS 6'h10
`define EXT_MODE_OFS 6'h14
`define WINDOW_OFS 6'h18
`define OFFSET_OFS 6'h1c
`define INT_STATUS_OFS 6'h20
`define INT_CLEAR_OFS 6'h24
`define INT_ENABLE_OFS 6'h28
`define LAST_DATA_OFS 6'h2c

// Control register
`define CTRL_START_BIT 0
// Mode register
`define MODE_USER_SEQ_BIT 0
`define MODE_PER_CHAN_BIT 1
// Extended mode register
`define EXT_CMP_MODE_LSB 0
`define EXT_CMP_SEL_LSB 4
`define EXT_CMP_ALL_BIT 9
// Compare window register
`define WIN_LOW_LSB 0
`define WIN_HIGH_LSB 16
// Interrupt status layout
`define INT_COMPARE_BIT 0
`define INT_SEQ_DONE_BIT 1
`define INT_WIDTH 2
// Last data register
`define LAST_CHAN_LSB 12
`define LAST_INPUT_PAIRING_SELECT_BIT 16

// Compare threshold select codes
`define CMP_BELOW_LOW 2'h0
`define CMP_ABOVE_HIGH 2'h1
`define CMP_INSIDE 2'h2
`define CMP_OUTSIDE 2'h3

// Reset values
`define RESET_ZERO 32'h0000_0000

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/adc_sequence_compare_ctrl.v ----
// Purpose: conversion sequencer, window compare and input pairing control of the converter
// Assumes: one clock, synchronous active-high reset, AXI4-Lite register access
// Notes: the converter core answers each start with one conv_done pulse carrying its result
// What this block does
// [R01] With user sequencing enabled, slot fields of the two sequence registers set the order.
// [R02] The user sequence has 16 slots, each naming any channel, repeats allowed.
// [R03] Only slots whose matching enable bit is set join, slot x paired with enable bit x.
// [R04] Software must not place a channel unusable for conversion into any slot.
// [R05] Conversions per trigger are bounded by enabled bits, one enabled slot per conversion.
// [R06] Results are compared against the low, the high or both thresholds as selected.
// [R07] Compare applies to the selected channel only, or to every channel when so set.
// [R08] A compare match sets the compare event flag, which can raise the interrupt.
// [R09] High and low thresholds are held in the window register, readable and writable.
// [R10] The pairing bit selects single-ended when 0 and differential when 1.
// [R11] After reset the converter works single-ended until software picks differential.
// [R12] With per-channel analog setting set, each channel uses its own pairing bit.
// [R13] With per-channel analog setting clear, the first channel's pairing applies to all.
// [R14] Single-ended selection addresses 16 inputs, differential addresses 8 pairs.
// [R15] Each trigger walks enabled slots in ascending order, one conversion each, then idles.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`include "adc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module adc_sequence_compare_ctrl #(
   parameter DATA_W = 12,
   parameter CHANNELS = 16
) (
   input wire clk,
   input wire rst,
   // AXI4-Lite slave
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Trigger and converter core
   input wire trigger,
   output reg conv_start,
   output reg [3:0] conv_channel,
   output reg [3:0] mux_addr,
   output reg input_pairing,
   input wire conv_done,
   input wire [DATA_W-1:0] conv_data,
   output reg busy,
   output reg irq
);

   localparam CH_W = 4;
   localparam ST_IDLE = 2'h0;
   localparam ST_FIND = 2'h1;
   localparam ST_START = 2'h2;
   localparam ST_WAIT = 2'h3;

   // Software registers
   reg [1:0] mode_r;
   reg [31:0] seq_low_r;
   reg [31:0] seq_high_r;
   reg [CHANNELS-1:0] chan_en_r;
   reg [9:0] ext_mode_r;
   reg [DATA_W-1:0] win_low_r;
   reg [DATA_W-1:0] win_high_r;
   reg [CHANNELS-1:0] pairing_r;
   reg [`INT_WIDTH-1:0] int_status_r;
   reg [`INT_WIDTH-1:0] int_enable_r;
   reg [DATA_W-1:0] last_data_r;
   reg [CH_W-1:0] last_chan_r;
   reg last_input_pairing_select_r;
   reg sw_start_r;

   // Bus slave state
   reg aw_have_r;
   reg w_have_r;
   reg [5:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg [31:0] rd_nxt;
   reg rd_ok_nxt;
   reg wr_ok_nxt;

   // Sequencer state
   reg [1:0] state_r;
   reg [CH_W:0] slot_r;
   reg [CH_W-1:0] cur_chan_r;

   wire [63:0] slot_fields;
   wire [CH_W-1:0] slot_chan [0:CHANNELS-1];
   wire pick_found;
   wire [CH_W-1:0] pick_index;
   wire cmp_match;
   wire chan_input_pairing_select;
   wire do_write;
   wire [31:0] keep;
   wire [31:0] wr_bits;
   wire [`INT_WIDTH-1:0] int_set;
   wire [`INT_WIDTH-1:0] int_clear;

   // [R01] Slot fields or default order, slot x converting channel x
   assign slot_fields = mode_r[`MODE_USER_SEQ_BIT] ? {seq_high_r, seq_low_r} :
      64'hfedc_ba98_7654_3210;
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : gen_slot
         assign slot_chan[g] = slot_fields[g*CH_W +: CH_W];
      end
   endgenerate

   // [R03] Enabled slots only
   slot_picker #(
      .SLOTS(CHANNELS),
      .IDX_W(CH_W)
   ) u_picker (
      .enable(chan_en_r),
      .start(slot_r),
      .found(pick_found),
      .index(pick_index)
   );

   window_compare #(
      .DATA_W(DATA_W),
      .CH_W(CH_W)
   ) u_compare (
      .data(conv_data),
      .channel(cur_chan_r),
      .low(win_low_r),
      .high(win_high_r),
      .compare_threshold_select(ext_mode_r[`EXT_CMP_MODE_LSB +: 2]),
      .compare_channel_select(ext_mode_r[`EXT_CMP_SEL_LSB +: CH_W]),
      .compare_every_channel(ext_mode_r[`EXT_CMP_ALL_BIT]),
      .match(cmp_match)
   );

   // [R12] Own pairing bit per channel
   // [R13] Otherwise the first channel's bit
   assign chan_input_pairing_select = mode_r[`MODE_PER_CHAN_BIT] ?
      pairing_r[slot_chan[pick_index]] : pairing_r[0];

   // Unset byte lanes keep the old register bits
   assign keep = ~{{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign wr_bits = w_data_r & ~keep;
   // Write channel acceptance, address and data in either order
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   always @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r <= `RESET_ZERO;
         w_strb_r <= 4'h0;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have_r && !s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_have_r && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok_nxt ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Write address decode; read-only offsets answer with an error
   always @* begin
      case (aw_addr_r)
         `CTRL_OFS, `MODE_OFS, `SEQ_LOW_OFS, `SEQ_HIGH_OFS, `CHAN_EN_OFS,
         `EXT_MODE_OFS, `WINDOW_OFS, `OFFSET_OFS, `INT_CLEAR_OFS,
         `INT_ENABLE_OFS: wr_ok_nxt = 1'b1;
         default: wr_ok_nxt = 1'b0;
      endcase
   end

   // Register writes
   always @(posedge clk) begin
      if (rst) begin
         mode_r <= 2'h0;
         seq_low_r <= `RESET_ZERO;
         seq_high_r <= `RESET_ZERO;
         chan_en_r <= {CHANNELS{1'b0}};
         ext_mode_r <= 10'h000;
         win_low_r <= {DATA_W{1'b0}};
         win_high_r <= {DATA_W{1'b0}};
         // [R11] Single-ended after reset
         pairing_r <= {CHANNELS{1'b0}};
         int_enable_r <= {`INT_WIDTH{1'b0}};
         sw_start_r <= 1'b0;
      end else begin
         sw_start_r <= 1'b0;
         if (do_write) begin
            case (aw_addr_r)
               `CTRL_OFS: sw_start_r <= w_strb_r[0] && w_data_r[`CTRL_START_BIT];
               `MODE_OFS: mode_r <= (mode_r & keep[1:0]) | wr_bits[1:0];
               `SEQ_LOW_OFS: seq_low_r <= (seq_low_r & keep) | wr_bits;
               `SEQ_HIGH_OFS: seq_high_r <= (seq_high_r & keep) | wr_bits;
               `CHAN_EN_OFS: chan_en_r <= (chan_en_r & keep[CHANNELS-1:0]) | wr_bits[CHANNELS-1:0];
               `EXT_MODE_OFS: ext_mode_r <= (ext_mode_r & keep[9:0]) | wr_bits[9:0];
               // [R09] Thresholds written
               `WINDOW_OFS: begin
                  win_low_r <= (win_low_r & keep[DATA_W-1:0]) | wr_bits[DATA_W-1:0];
                  win_high_r <= (win_high_r & keep[`WIN_HIGH_LSB +: DATA_W]) |
                     wr_bits[`WIN_HIGH_LSB +: DATA_W];
               end
               // [R10] Pairing select bits
               `OFFSET_OFS: pairing_r <= (pairing_r & keep[CHANNELS-1:0]) | wr_bits[CHANNELS-1:0];
               `INT_ENABLE_OFS: int_enable_r <= (int_enable_r & keep[1:0]) | wr_bits[1:0];
               default: sw_start_r <= 1'b0;
            endcase
         end
      end
   end

   // Read data mux
   always @* begin
      rd_nxt = `RESET_ZERO;
      rd_ok_nxt = 1'b1;
      case (s_axi_araddr)
         `MODE_OFS: rd_nxt[1:0] = mode_r;
         `SEQ_LOW_OFS: rd_nxt = seq_low_r;
         `SEQ_HIGH_OFS: rd_nxt = seq_high_r;
         `CHAN_EN_OFS: rd_nxt[CHANNELS-1:0] = chan_en_r;
         `EXT_MODE_OFS: rd_nxt[9:0] = ext_mode_r;
         // [R09] Thresholds read back
         `WINDOW_OFS: begin
            rd_nxt[`WIN_LOW_LSB +: DATA_W] = win_low_r;
            rd_nxt[`WIN_HIGH_LSB +: DATA_W] = win_high_r;
         end
         `OFFSET_OFS: rd_nxt[CHANNELS-1:0] = pairing_r;
         `INT_STATUS_OFS: rd_nxt[`INT_WIDTH-1:0] = int_status_r;
         `INT_ENABLE_OFS: rd_nxt[`INT_WIDTH-1:0] = int_enable_r;
         `LAST_DATA_OFS: begin
            rd_nxt[DATA_W-1:0] = last_data_r;
            rd_nxt[`LAST_CHAN_LSB +: CH_W] = last_chan_r;
            rd_nxt[`LAST_INPUT_PAIRING_SELECT_BIT] = last_input_pairing_select_r;
         end
         // Write-only registers read as zero
         `CTRL_OFS, `INT_CLEAR_OFS: rd_nxt = `RESET_ZERO;
         default: rd_ok_nxt = 1'b0;
      endcase
   end

   // Read channel: one request at a time
   always @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `RESET_ZERO;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_ok_nxt ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Conversion sequencer
   always @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         slot_r <= 5'h00;
         cur_chan_r <= 4'h0;
         conv_start <= 1'b0;
         conv_channel <= 4'h0;
         mux_addr <= 4'h0;
         input_pairing <= 1'b0;
         busy <= 1'b0;
         last_data_r <= {DATA_W{1'b0}};
         last_chan_r <= 4'h0;
         last_input_pairing_select_r <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         case (state_r)
            // Triggers arriving while busy are dropped
            ST_IDLE: begin
               if (trigger || sw_start_r) begin
                  slot_r <= 5'h00;
                  busy <= 1'b1;
                  state_r <= ST_FIND;
               end
            end
            // [R15] Ascending walk of enabled slots
            ST_FIND: begin
               // [R05] Ends once enabled slots run out
               if (pick_found) begin
                  // [R02] Any channel, repeats allowed
                  cur_chan_r <= slot_chan[pick_index];
                  conv_channel <= slot_chan[pick_index];
                  input_pairing <= chan_input_pairing_select;
                  // [R14] Sixteen inputs or eight pairs
                  mux_addr <= chan_input_pairing_select ? {1'b0, slot_chan[pick_index][CH_W-1:1]} :
                     slot_chan[pick_index];
                  slot_r <= {1'b0, pick_index} + 5'h01;
                  state_r <= ST_START;
               end else begin
                  busy <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            ST_START: begin
               conv_start <= 1'b1;
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done) begin
                  last_data_r <= conv_data;
                  last_chan_r <= cur_chan_r;
                  last_input_pairing_select_r <= input_pairing;
                  state_r <= ST_FIND;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // [R08] Match raises the compare event flag
   assign int_set[`INT_COMPARE_BIT] = (state_r == ST_WAIT) && conv_done && cmp_match;
   assign int_set[`INT_SEQ_DONE_BIT] = (state_r == ST_FIND) && !pick_found;
   assign int_clear = (do_write && (aw_addr_r == `INT_CLEAR_OFS) && w_strb_r[0]) ?
      w_data_r[`INT_WIDTH-1:0] : {`INT_WIDTH{1'b0}};

   // Set wins over a clear in the same cycle
   always @(posedge clk) begin
      if (rst) begin
         int_status_r <= {`INT_WIDTH{1'b0}};
         irq <= 1'b0;
      end else begin
         int_status_r <= (int_status_r & ~int_clear) | int_set;
         // [R08] Enabled flag drives the interrupt
         irq <= |(((int_status_r & ~int_clear) | int_set) & int_enable_r);
      end
   end

endmodule // adc_sequence_compare_ctrl

`default_nettype wire

// ---- core/slot_picker.v ----
// Purpose: finds the lowest enabled sequence slot at or above a start index
// Assumes: purely combinational, one enable bit per slot
// Notes: found is low when no enabled slot remains
`timescale 1ns/1ps
`default_nettype none

module slot_picker #(
   parameter SLOTS = 16,
   parameter IDX_W = 4
) (
   input wire [SLOTS-1:0] enable,
   input wire [IDX_W:0] start,
   output reg found,
   output reg [IDX_W-1:0] index
);

   wire [SLOTS-1:0] eligible;
   integer k;

   genvar g;
   generate
      for (g = 0; g < SLOTS; g = g + 1) begin : gen_elig
         assign eligible[g] = enable[g] && (g >= start);
      end
   endgenerate

   // Scan downward so the lowest eligible slot wins
   always @* begin
      found = 1'b0;
      index = {IDX_W{1'b0}};
      for (k = SLOTS - 1; k >= 0; k = k - 1) begin
         if (eligible[k]) begin
            found = 1'b1;
            index = k[IDX_W-1:0];
         end
      end
   end

endmodule // slot_picker

`default_nettype wire

// ---- core/window_compare.v ----
// Purpose: compares one converted value against the low and high thresholds
// Assumes: thresholds and data share one width
// Notes: match is combinational; the caller qualifies it with the result strobe
`include "adc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module window_compare #(
   parameter DATA_W = 12,
   parameter CH_W = 4
) (
   input wire [DATA_W-1:0] data,
   input wire [CH_W-1:0] channel,
   input wire [DATA_W-1:0] low,
   input wire [DATA_W-1:0] high,
   input wire [1:0] compare_threshold_select,
   input wire [CH_W-1:0] compare_channel_select,
   input wire compare_every_channel,
   output reg match
);

   reg hit;

   always @* begin
      // [R06] Threshold choice
      case (compare_threshold_select)
         `CMP_BELOW_LOW: hit = data < low;
         `CMP_ABOVE_HIGH: hit = data > high;
         `CMP_INSIDE: hit = (data >= low) && (data <= high);
         default: hit = (data < low) || (data > high);
      endcase
      // [R07] One channel or all
      match = hit && (compare_every_channel || (channel == compare_channel_select));
   end

endmodule // window_compare

`default_nettype wire

// ---- verification/adc_ctrl_props.sv ----
// Purpose: port-level checks of the converter sequencer and its register slave
// Assumes: single clock, synchronous active-high reset
// Notes: bound into the top module, sees only its ports
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic trigger,
   input wire logic busy,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic [3:0] mux_addr,
   input wire logic input_pairing,
   input wire logic conv_done,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_trig_accept;
      trigger && !busy |=> busy;
   endproperty
   a_trig_accept: assert property (p_trig_accept)
      else $error("trigger in idle did not raise busy");
   property p_idle_quiet;
      !busy |-> !conv_start;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("conversion started while idle");
   property p_mux_map;
      conv_start |-> mux_addr == (input_pairing ? {1'b0, conv_channel[3:1]} : conv_channel);
   endproperty
   a_mux_map: assert property (p_mux_map)
      else $error("mux address does not fit channel and pairing");
   property p_chan_hold;
      conv_start |=> ($stable(conv_channel) && $stable(input_pairing))[*2];
   endproperty
   a_chan_hold: assert property (p_chan_hold)
      else $error("channel changed during conversion");
   property p_next_slot;
      conv_done && busy |-> ##[1:4] (conv_start || !busy);
   endproperty
   a_next_slot: assert property (p_next_slot)
      else $error("sequence stalled after a result");
   property p_start_pulse;
      conv_start |=> !conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start longer than one cycle");
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse)
      else $error("awready longer than one cycle");
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop)
      else $error("bvalid held after handshake");
   property p_r_after_ar;
      $rose(s_axi_rvalid) |-> $past(s_axi_arready);
   endproperty
   a_r_after_ar: assert property (p_r_after_ar)
      else $error("rvalid not one cycle after arready");
   property p_ar_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_refuse: assert property (p_ar_refuse)
      else $error("read accepted while data pending");
endmodule // adc_ctrl_props

bind adc_sequence_compare_ctrl adc_ctrl_props u_props (
   .clk(clk), .rst(rst), .trigger(trigger), .busy(busy), .conv_start(conv_start),
   .conv_channel(conv_channel), .mux_addr(mux_addr), .input_pairing(input_pairing),
   .conv_done(conv_done), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// ---- verification/conv_core_model.sv ----
// Purpose: behavioural converter core answering each start with one result
// Assumes: result is {channel, 8'h10}, channel held during conversion
// Notes: slow adds six cycles; data toggles outside the result cycle
`timescale 1ns/1ps
`default_nettype none

module conv_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic slow,
   output logic conv_done,
   output logic [11:0] conv_data
);
   logic [3:0] wait_r;
   logic run_r;
   always @(posedge clk) begin
      conv_done <= 1'b0;
      if (rst) begin
         run_r <= 1'b0;
         wait_r <= 4'h0;
         conv_data <= 12'h000;
      end else if (conv_start) begin
         run_r <= 1'b1;
         wait_r <= slow ? 4'h6 : 4'h0;
         conv_data <= ~conv_data;
      end else if (run_r && wait_r == 4'h0) begin
         run_r <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= {conv_channel, 8'h10};
      end else begin
         if (run_r) wait_r <= wait_r - 4'h1;
         // No stale result may look valid
         conv_data <= ~conv_data;
      end
   end
endmodule // conv_core_model
`default_nettype wire

// ---- verification/tb_adc_sequence_compare_ctrl.sv ----
// Purpose: self-checking bench of the sequencer, window compare and pairing
// Assumes: register master speaks AXI4-Lite, converter core is modelled
// Notes: expected values come from the register layout and the model's data
`include "adc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module tb_adc_sequence_compare_ctrl;
   logic clk = 1'b0, rst = 1'b1, trigger = 1'b0, slow = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic conv_start, input_pairing, conv_done, busy, irq;
   logic [3:0] conv_channel, mux_addr;
   logic [11:0] conv_data;
   logic [3:0] obs_ch[$], obs_mux[$];
   logic obs_pair[$];
   logic [19:0] cmp_tab [0:8] = '{20'h5_0500, 20'h5_0510, 20'h5_0521, 20'h5_0530,
      20'h5_0720, 20'h5_2721, 20'h9_0911, 20'h9_0931, 20'h0_0001};
   int err_count = 0, check_count = 0, cycles = 0, i, a;
   logic [31:0] rd;
   logic [1:0] rsp;

   adc_sequence_compare_ctrl dut (.clk(clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .trigger(trigger), .conv_start(conv_start), .conv_channel(conv_channel),
      .mux_addr(mux_addr), .input_pairing(input_pairing), .conv_done(conv_done),
      .conv_data(conv_data), .busy(busy), .irq(irq));
   conv_core_model core_model (.clk(clk), .rst(rst), .conv_start(conv_start),
      .conv_channel(conv_channel), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      if (!rst && conv_start) begin
         obs_ch.push_back(conv_channel);
         obs_mux.push_back(mux_addr);
         obs_pair.push_back(input_pairing);
      end
   end

   task automatic conclude();
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         err_count++;
         conclude();
      end
   end

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [5:0] adr, input logic [31:0] dat, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= adr;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [5:0] adr, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= adr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic run_seq(input int n, input logic [63:0] chs, input logic [15:0] prs,
      input logic [1:0] how);
      int k;
      logic [3:0] ch;
      obs_ch.delete();
      obs_mux.delete();
      obs_pair.delete();
      // Start by the control register or by the trigger pin
      if (how == 2'h2) axi_write(`CTRL_OFS, 32'h0000_0001, rsp);
      else begin
         @(posedge clk);
         trigger <= 1'b1;
         @(posedge clk);
         trigger <= 1'b0;
      end
      while (!busy) @(posedge clk);
      // A trigger while busy must not queue
      if (how == 2'h1) begin
         repeat (3) @(posedge clk);
         trigger <= 1'b1;
         @(posedge clk);
         trigger <= 1'b0;
      end
      while (busy) @(posedge clk);
      repeat (2) @(posedge clk);
      check_word(32'(obs_ch.size()), 32'(n));
      for (k = 0; k < n; k++) begin
         ch = chs[4*k +: 4];
         check_word({28'h0, obs_ch[k]}, {28'h0, ch});
         check_word({31'h0, obs_pair[k]}, {31'h0, prs[k]});
         check_word({28'h0, obs_mux[k]}, {28'h0, prs[k] ? {1'b0, ch[3:1]} : ch});
      end
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (a = 4; a <= 44; a += 4) begin
         if (a != 36) begin
            axi_read(6'(a), rd, rsp);
            check_word(rd, `RESET_ZERO);
         end
      end
      check_word({31'h0, irq}, 32'h0000_0000);
      axi_read(6'h30, rd, rsp);
      check_word({rd[31:2], rsp}, {30'h0, `RESP_SLVERR});
      axi_write(`INT_STATUS_OFS, 32'h0000_0003, rsp);
      check_word({30'h0, rsp}, {30'h0, `RESP_SLVERR});
      axi_write(`WINDOW_OFS, 32'h0600_0300, rsp);
      axi_read(`WINDOW_OFS, rd, rsp);
      check_word(rd, 32'h0600_0300);
      check_word({30'h0, rsp}, {30'h0, `RESP_OKAY});
      // Default order, slow core, retrigger ignored
      slow <= 1'b1;
      axi_write(`CHAN_EN_OFS, 32'h0000_0005, rsp);
      run_seq(2, 64'h0000_0000_0000_0020, 16'h0000, 2'h1);
      slow <= 1'b0;
      // Enabled slots 0, 1, 3 and 15 name channels 3, 3, 0 and 15
      axi_write(`SEQ_LOW_OFS, 32'h0000_0f33, rsp);
      axi_write(`SEQ_HIGH_OFS, 32'hf000_0000, rsp);
      axi_write(`CHAN_EN_OFS, 32'h0000_800b, rsp);
      axi_write(`MODE_OFS, 32'h0000_0001, rsp);
      run_seq(4, 64'h0000_0000_0000_f033, 16'h0000, 2'h0);
      axi_write(`OFFSET_OFS, 32'h0000_0001, rsp);
      run_seq(4, 64'h0000_0000_0000_f033, 16'h000f, 2'h0);
      axi_write(`MODE_OFS, 32'h0000_0003, rsp);
      run_seq(4, 64'h0000_0000_0000_f033, 16'h0004, 2'h2);
      axi_write(`MODE_OFS, 32'h0000_0000, rsp);
      axi_write(`OFFSET_OFS, 32'h0000_0000, rsp);
      axi_write(`INT_ENABLE_OFS, 32'h0000_0001, rsp);
      for (i = 0; i < 9; i++) begin
         axi_write(`INT_CLEAR_OFS, 32'h0000_0003, rsp);
         axi_write(`CHAN_EN_OFS, 32'h0000_0001 << cmp_tab[i][19:16], rsp);
         axi_write(`EXT_MODE_OFS, {20'h0_0000, cmp_tab[i][15:4]}, rsp);
         run_seq(1, 64'(cmp_tab[i][19:16]), 16'h0000, 2'h0);
         axi_read(`INT_STATUS_OFS, rd, rsp);
         check_word({31'h0, rd[0]}, {31'h0, cmp_tab[i][0]});
         check_word({31'h0, irq}, {31'h0, cmp_tab[i][0]});
      end
      axi_write(`INT_ENABLE_OFS, 32'h0000_0000, rsp);
      repeat (2) @(posedge clk);
      check_word({31'h0, irq}, 32'h0000_0000);
      axi_write(`INT_ENABLE_OFS, 32'h0000_0001, rsp);
      repeat (2) @(posedge clk);
      check_word({31'h0, irq}, 32'h0000_0001);
      axi_write(`INT_CLEAR_OFS, 32'h0000_0001, rsp);
      axi_read(`INT_STATUS_OFS, rd, rsp);
      check_word({29'h0, rd[1], irq, rd[0]}, 32'h0000_0004);
      conclude();
   end
endmodule // tb_adc_sequence_compare_ctrl
`default_nettype wire
